/* File: pkg/sfe_pkg.sv */
/*
  Package for the serial flash SPI front end: instruction codes, frame
  layout, frame phase states and the user-side carrier structs.
  Assumes one 25 MHz system clock that oversamples the SPI pins.
*/
package sfe_pkg;

  localparam int          SFE_OPCODE_BITS = 8;
  localparam int          SFE_ADDR_BITS   = 24;
  localparam logic [7:0]  SFE_OP_WRSR     = 8'h01;
  localparam logic [7:0]  SFE_OP_READ     = 8'h03;
  localparam logic [7:0]  SFE_OP_FREAD    = 8'h0B;
  localparam logic [7:0]  SFE_OP_DREAD    = 8'h3B;
  localparam logic [7:0]  SFE_OP_RDSR     = 8'h05;
  localparam logic [5:0]  SFE_CNT_RST     = 6'h00;
  localparam logic [7:0]  SFE_SHIFT_RST   = 8'h00;
  localparam logic [5:0]  SFE_DUMMY_END   = 6'h27;
  localparam logic [5:0]  SFE_ADDR_END    = 6'h1F;
  localparam int          SFE_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SFE_ST_OPCODE = 2'b00,
    SFE_ST_ADDR   = 2'b01,
    SFE_ST_DATA   = 2'b10,
    SFE_ST_IGNORE = 2'b11
  } sfe_phase_t;

  // request towards the memory core
  typedef struct packed {
    logic        op_valid;
    logic [7:0]  opcode;
    logic        addr_valid;
    logic [23:0] addr;
    logic        byte_valid;
    logic [7:0]  wr_byte;
    logic        sr_write_ok;
  } sfe_req_t;

  // pin drive bundle
  typedef struct packed {
    logic dout;
    logic dout_oe_n;
    logic dio_out;
    logic dio_oe_n;
  } sfe_pins_t;

endpackage

/* File: rtl/sfe_sync.sv */
/*
  Two-flop level synchroniser for one pin, with a reset value.
  Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/10ps
module sfe_sync
  import sfe_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock_i,  // system clock
  input  wire logic rstn_i,   // async reset, active low
  input  wire logic d_i,      // async pin level
  output logic      q_o       // synchronised level
);
  logic meta_reg;
  logic q_reg;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

/* File: rtl/sfe_front_end.sv */
/*
  SPI slave front end of a serial flash: select gating, mode 0/3 edge
  handling, single and dual output read, and the pause function.
  Assumes the serial clock is far slower than clock_i (320 ns vs 40 ns)
  and that the memory core supplies read bytes on rd_byte_i when asked.
*/
`timescale 1ns/10ps
module sfe_front_end
  import sfe_pkg::*;
(
  input  wire logic       clock_i,       // 25 MHz system clock
  input  wire logic       rstn_i,        // async reset, active low
  input  wire logic       cs_n_i,        // chip select pin, active low
  input  wire logic       sclk_i,        // serial clock pin
  input  wire logic       serial_inout_pin_i, // inout pin, input side
  output logic            serial_inout_pin_o, // inout pin, output side
  output logic            serial_inout_pin_oe_n_o, // low while driving
  output logic            dout_o,        // data output pin
  output logic            dout_oe_n_o,   // low while driving
  input  wire logic       wp_n_i,        // write protect pin, active low
  input  wire logic       pause_n_i,     // pause pin, active low
  input  wire logic       sr_protect_i,  // protect bit from status core
  input  wire logic [7:0] rd_byte_i,     // next read byte from core
  output logic            rd_next_o,     // pulse: byte taken, advance
  output sfe_req_t        req_o,         // request bundle to core
  output logic            paused_o,      // level: pause active
  output logic            armed_o        // level: first select seen
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic cs_n_s, sclk_s, dio_s, wp_n_s, pause_n_s;

  sfe_sync #(.RST_VAL(1'b1)) u_cs   (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(cs_n_i),             .q_o(cs_n_s));
  sfe_sync #(.RST_VAL(1'b0)) u_sclk (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(sclk_i),             .q_o(sclk_s));
  sfe_sync #(.RST_VAL(1'b0)) u_dio  (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(serial_inout_pin_i), .q_o(dio_s));
  sfe_sync #(.RST_VAL(1'b1)) u_wp   (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(wp_n_i),             .q_o(wp_n_s));
  sfe_sync #(.RST_VAL(1'b1)) u_hold (.clock_i(clock_i), .rstn_i(rstn_i), .d_i(pause_n_i),          .q_o(pause_n_s));

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic sclk_d_reg, cs_d_reg, pause_d_reg;
  logic sclk_rise, sclk_fall, cs_fall, pause_fall, pause_rise;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_reg  <= 1'b0;
      cs_d_reg    <= 1'b1;
      pause_d_reg <= 1'b1;
    end else begin
      sclk_d_reg  <= sclk_s;
      cs_d_reg    <= cs_n_s;
      pause_d_reg <= pause_n_s;
    end
  end

  // edges found from level changes only, so idle level is irrelevant
  assign sclk_rise  = sclk_s & ~sclk_d_reg;
  assign sclk_fall  = ~sclk_s & sclk_d_reg;
  assign cs_fall    = ~cs_n_s & cs_d_reg;
  assign pause_fall = ~pause_n_s & pause_d_reg;
  assign pause_rise = pause_n_s & ~pause_d_reg;

  logic selected;
  assign selected = ~cs_n_s;

  // ----------------------------------------
  // arming after reset
  // ----------------------------------------
  logic armed_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_reg <= 1'b0;
    end else if (cs_fall) begin
      armed_reg <= 1'b1;
    end
  end
  assign armed_o = armed_reg;

  // ----------------------------------------
  // pause state
  // ----------------------------------------
  logic paused_reg, pend_on_reg, pend_off_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      paused_reg   <= 1'b0;
      pend_on_reg  <= 1'b0;
      pend_off_reg <= 1'b0;
    end else if (!selected) begin
      paused_reg   <= 1'b0;
      pend_on_reg  <= 1'b0;
      pend_off_reg <= 1'b0;
    end else begin
      if (pause_fall) begin
        pend_off_reg <= 1'b0;
        if (!sclk_s) paused_reg <= 1'b1;
        else pend_on_reg <= 1'b1;
      end else if (pause_rise) begin
        pend_on_reg <= 1'b0;
        if (!sclk_s) paused_reg <= 1'b0;
        else pend_off_reg <= 1'b1;
      end else if (sclk_fall) begin
        if (pend_on_reg) paused_reg <= 1'b1;
        if (pend_off_reg) paused_reg <= 1'b0;
        pend_on_reg  <= 1'b0;
        pend_off_reg <= 1'b0;
      end
    end
  end
  assign paused_o = paused_reg;

  // clock edges reach the shifter only while selected, armed, not paused
  logic active, rise_ok, fall_ok;
  assign active  = selected & armed_reg & ~paused_reg;
  assign rise_ok = active & sclk_rise;
  // the fall that starts a pause still shifts; the one that ends it does not
  assign fall_ok = active & sclk_fall & ~pend_off_reg;

  // ----------------------------------------
  // input shifter and frame decode
  // ----------------------------------------
  sfe_phase_t phase_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [2:0]  byte_bit_reg;
  logic        dual_reg;
  logic        out_en_reg;
  logic [7:0]  shift_next;
  assign shift_next = {shift_reg[6:0], dio_s};

  logic op_valid_reg, addr_valid_reg, byte_valid_reg;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg      <= SFE_ST_OPCODE;
      bit_cnt_reg    <= SFE_CNT_RST;
      shift_reg      <= SFE_SHIFT_RST;
      opcode_reg     <= SFE_SHIFT_RST;
      addr_reg       <= '0;
      byte_bit_reg   <= 3'h0;
      op_valid_reg   <= 1'b0;
      addr_valid_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
    end else begin
      op_valid_reg   <= 1'b0;
      addr_valid_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
      if (!selected) begin
        phase_reg    <= SFE_ST_OPCODE;
        bit_cnt_reg  <= SFE_CNT_RST;
        byte_bit_reg <= 3'h0;
      end else if (rise_ok) begin
        shift_reg   <= shift_next;
        // saturate so long reads keep streaming
        if (bit_cnt_reg != 6'h3F) bit_cnt_reg <= bit_cnt_reg + 6'h01;
        case (phase_reg)
          SFE_ST_OPCODE: begin
            if (bit_cnt_reg == 6'h07) begin
              opcode_reg   <= shift_next;
              op_valid_reg <= 1'b1;
              case (shift_next)
                SFE_OP_READ, SFE_OP_FREAD, SFE_OP_DREAD: phase_reg <= SFE_ST_ADDR;
                default: phase_reg <= SFE_ST_DATA;
              endcase
            end
          end
          SFE_ST_ADDR: begin
            addr_reg <= {addr_reg[22:0], dio_s};
            if (bit_cnt_reg == SFE_ADDR_END) begin
              addr_valid_reg <= 1'b1;
              phase_reg      <= SFE_ST_IGNORE;  // reads carry no write bytes
            end
          end
          SFE_ST_DATA: begin
            byte_bit_reg <= byte_bit_reg + 3'h1;
            if (byte_bit_reg == 3'h7) byte_valid_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // output starts after address for plain read, after dummy byte for fast reads
  logic out_start;
  assign out_start = (opcode_reg == SFE_OP_READ) ? (bit_cnt_reg > SFE_ADDR_END)
                                                 : (bit_cnt_reg > SFE_DUMMY_END);
  logic is_read;
  assign is_read = (opcode_reg == SFE_OP_READ) | (opcode_reg == SFE_OP_FREAD)
                 | (opcode_reg == SFE_OP_DREAD) | (opcode_reg == SFE_OP_RDSR);

  // ----------------------------------------
  // output shifter, falling edges only
  // ----------------------------------------
  logic [7:0] out_sr_reg;
  logic [2:0] out_cnt_reg;
  logic       dout_reg, dio_out_reg, rd_next_reg;
  logic       rdsr_start;
  assign rdsr_start = (opcode_reg == SFE_OP_RDSR) && (bit_cnt_reg >= 6'h08);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_sr_reg  <= SFE_SHIFT_RST;
      out_cnt_reg <= 3'h0;
      dout_reg    <= 1'b0;
      dio_out_reg <= 1'b0;
      dual_reg    <= 1'b0;
      out_en_reg  <= 1'b0;
      rd_next_reg <= 1'b0;
    end else begin
      rd_next_reg <= 1'b0;
      if (!selected) begin
        out_cnt_reg <= 3'h0;
        dual_reg    <= 1'b0;
        out_en_reg  <= 1'b0;
      end else if (fall_ok && is_read && (out_start || rdsr_start)) begin
        out_en_reg <= 1'b1;
        dual_reg   <= (opcode_reg == SFE_OP_DREAD);
        if (out_cnt_reg == 3'h0) begin
          if (opcode_reg == SFE_OP_DREAD) begin
            dio_out_reg <= rd_byte_i[7];
            dout_reg    <= rd_byte_i[6];
            out_sr_reg  <= {rd_byte_i[5:0], 2'b00};
            out_cnt_reg <= 3'h3;
          end else begin
            dout_reg    <= rd_byte_i[7];
            out_sr_reg  <= {rd_byte_i[6:0], 1'b0};
            out_cnt_reg <= 3'h7;
          end
          rd_next_reg <= 1'b1;
        end else if (dual_reg) begin
          dio_out_reg <= out_sr_reg[7];
          dout_reg    <= out_sr_reg[6];
          out_sr_reg  <= {out_sr_reg[5:0], 2'b00};
          out_cnt_reg <= out_cnt_reg - 3'h1;
        end else begin
          dout_reg    <= out_sr_reg[7];
          out_sr_reg  <= {out_sr_reg[6:0], 1'b0};
          out_cnt_reg <= out_cnt_reg - 3'h1;
        end
      end
    end
  end

  assign rd_next_o               = rd_next_reg;
  assign dout_o                  = dout_reg;
  assign serial_inout_pin_o      = dio_out_reg;
  assign dout_oe_n_o             = ~(selected & out_en_reg & ~paused_reg);
  assign serial_inout_pin_oe_n_o = ~(selected & out_en_reg & dual_reg & ~paused_reg);

  // ----------------------------------------
  // core request
  // ----------------------------------------
  always_comb begin
    req_o             = '0;
    req_o.op_valid    = op_valid_reg;
    req_o.opcode      = opcode_reg;
    req_o.addr_valid  = addr_valid_reg;
    req_o.addr        = addr_reg;
    req_o.byte_valid  = byte_valid_reg;
    req_o.wr_byte     = shift_reg;
    req_o.sr_write_ok = ~(sr_protect_i & ~wp_n_s);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_pause_low_clk;
    selected && !sclk_s && pause_fall;
  endsequence

  a_float_deselect: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !selected |-> dout_oe_n_o && serial_inout_pin_oe_n_o) else $error("output driven while deselected");
  a_arm_first_fall: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !armed_reg |-> !op_valid_reg) else $error("opcode before first select");
  a_sample_rise_only: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $changed(bit_cnt_reg) && selected |-> $past(rise_ok)) else $error("bit counted off rising edge");
  a_out_fall_only: assert property (@(posedge clock_i) disable iff (!rstn_i)
    selected && $past(selected) && $changed(dout_reg) |-> $past(fall_ok)) else $error("output changed off falling edge");
  a_dual_inout: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !serial_inout_pin_oe_n_o |-> opcode_reg == SFE_OP_DREAD) else $error("inout driven outside dual read");
  a_wp_blocks: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (sr_protect_i && !wp_n_s) |-> !req_o.sr_write_ok) else $error("status write not blocked");
  a_pause_deselect: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !selected |=> !paused_reg) else $error("pause while deselected");
  a_pause_enter: assert property (@(posedge clock_i) disable iff (!rstn_i)
    s_pause_low_clk |=> paused_reg) else $error("pause not entered");
  a_pause_leave: assert property (@(posedge clock_i) disable iff (!rstn_i)
    selected && !sclk_s && pause_rise |=> !paused_reg) else $error("pause not left");
  a_pause_freeze: assert property (@(posedge clock_i) disable iff (!rstn_i)
    paused_reg && selected |-> dout_oe_n_o ##1 $stable(bit_cnt_reg)) else $error("activity while paused");
  a_opcode_first: assert property (@(posedge clock_i) disable iff (!rstn_i)
    op_valid_reg |-> bit_cnt_reg == 6'h08) else $error("opcode not after eight bits");
endmodule

/* File: verification/sfe_spi_master.sv */
/*
  Behavioural SPI bus master facing the flash front end, with pause pin.
  Assumes clock_i is the 25 MHz system clock; the link runs 320 ns per bit.
*/
`timescale 1ns/10ps
module sfe_spi_master (
  input  wire logic clock_i,    // system clock, paces the link
  input  wire logic dout_i,     // device data output
  input  wire logic dio_i,      // device inout output value
  input  wire logic dio_oe_n_i, // device inout enable, low drives
  output logic      cs_n_o,     // chip select, active low
  output logic      sclk_o,     // serial clock
  output logic      pause_n_o,  // pause request, active low
  output logic      dio_lvl_o   // resolved inout wire level
);
  logic drv_en;
  logic drv_val;
  logic idle_lvl;

  // released wire shows the inverse of the last driven value
  assign dio_lvl_o = !dio_oe_n_i ? dio_i : (drv_en ? drv_val : ~drv_val);

  initial begin
    cs_n_o    = 1'b1;
    sclk_o    = 1'b0;
    pause_n_o = 1'b1;
    drv_en    = 1'b0;
    drv_val   = 1'b0;
    idle_lvl  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic select(input logic m3);
    idle_lvl = m3;
    sclk_o <= m3;
    drv_en <= 1'b1;
    tick(4);
    cs_n_o <= 1'b0;
    tick(4);
  endtask

  task automatic deselect();
    sclk_o <= idle_lvl;
    tick(4);
    cs_n_o <= 1'b1;
    drv_en <= 1'b0;
    tick(8);
  endtask

  // data set with the fall, held over the rise, sampled before next fall
  task automatic sbit(input logic b, output logic d0, output logic d1);
    sclk_o  <= 1'b0;
    drv_val <= b;
    tick(4);
    sclk_o <= 1'b1;
    tick(4);
    d0 = dout_i;
    d1 = dio_lvl_o;
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    logic d0;
    logic d1;
    for (int i = 7; i >= 0; i--) begin
      sbit(tx[i], d0, d1);
      rx[i] = d0;
    end
  endtask

  task automatic dual_byte(output logic [7:0] rx);
    logic d0;
    logic d1;
    drv_en <= 1'b0;
    for (int i = 3; i >= 0; i--) begin
      sbit(1'b0, d0, d1);
      rx[2*i+1] = d1;
      rx[2*i]   = d0;
    end
  endtask

  // clock edge while paused, inout toggled as junk
  task automatic half(input logic lvl, input int n);
    sclk_o  <= lvl;
    drv_val <= ~drv_val;
    tick(n);
  endtask

  task automatic set_pause(input logic lvl);
    pause_n_o <= lvl;
    tick(6);
  endtask
endmodule

/* File: verification/serial_flash_spi_front_end_tb.sv */
/*
  Self-checking bench for the flash SPI front end with a master model.
  Assumes sfe_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
module serial_flash_spi_front_end_tb;
  import sfe_pkg::*;
  logic clock_i, rstn_i, wp_n_i, sr_protect_i, dio_seen;
  logic cs_n, sclk, pause_n, dio_lvl, dio_o, dio_oe_n, dout, dout_oe_n;
  logic rd_next, paused, armed;
  logic [7:0] rd_byte_i, cap_op, cap_wr, rx0, rx1;
  logic [23:0] cap_addr;
  sfe_req_t req;
  int mismatches, check_count, cyc, op_cnt;

  sfe_front_end u_sfe_front_end (.clock_i(clock_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .serial_inout_pin_i(dio_lvl), .serial_inout_pin_o(dio_o), .serial_inout_pin_oe_n_o(dio_oe_n),
    .dout_o(dout), .dout_oe_n_o(dout_oe_n), .wp_n_i(wp_n_i), .pause_n_i(pause_n),
    .sr_protect_i(sr_protect_i), .rd_byte_i(rd_byte_i), .rd_next_o(rd_next), .req_o(req),
    .paused_o(paused), .armed_o(armed));
  sfe_spi_master u_sfe_spi_master (.clock_i(clock_i), .dout_i(dout), .dio_i(dio_o),
    .dio_oe_n_i(dio_oe_n), .cs_n_o(cs_n), .sclk_o(sclk), .pause_n_o(pause_n), .dio_lvl_o(dio_lvl));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // core side capture and timeout
  // ----------------------------------------
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (req.op_valid) begin
      cap_op <= req.opcode;
      op_cnt <= op_cnt + 1;
    end
    if (req.addr_valid) cap_addr <= req.addr;
    if (req.byte_valid) cap_wr <= req.wr_byte;
    if (rd_next) rd_byte_i <= rd_byte_i + 8'h11;
    if (!dio_oe_n) dio_seen <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_arm();
    check(armed, 1'b0, "armed before select");
    check(dout_oe_n, 1'b1, "output driven while deselected");
    u_sfe_spi_master.xbyte(SFE_OP_READ, rx0);
    check(24'(op_cnt), 24'h0, "opcode taken before select");
  endtask

  task automatic s_read(input logic m3, input logic [7:0] op, input logic [7:0] b0);
    rd_byte_i <= b0;
    dio_seen = 1'b0;
    u_sfe_spi_master.select(m3);
    check(armed, 1'b1, "not armed after select");
    u_sfe_spi_master.xbyte(op, rx0);
    u_sfe_spi_master.xbyte(8'h12, rx0);
    u_sfe_spi_master.xbyte(8'h34, rx0);
    u_sfe_spi_master.xbyte(8'h56, rx0);
    if (op != SFE_OP_READ) u_sfe_spi_master.xbyte(8'hFF, rx0);
    u_sfe_spi_master.xbyte(8'h00, rx0);
    u_sfe_spi_master.xbyte(8'h00, rx1);
    check(dout_oe_n, 1'b0, "output not driven");
    check(rx0, b0, "first read byte");
    check(rx1, b0 + 8'h11, "second read byte");
    check(dio_seen, 1'b0, "inout driven in single read");
    u_sfe_spi_master.deselect();
    check(dout_oe_n, 1'b1, "output driven after deselect");
    check(cap_op, op, "opcode");
    check(cap_addr, 24'h123456, "address");
  endtask

  task automatic s_dual();
    rd_byte_i <= 8'hC6;
    u_sfe_spi_master.select(1'b0);
    u_sfe_spi_master.xbyte(SFE_OP_DREAD, rx0);
    u_sfe_spi_master.xbyte(8'hAB, rx0);
    u_sfe_spi_master.xbyte(8'hCD, rx0);
    u_sfe_spi_master.xbyte(8'hEF, rx0);
    u_sfe_spi_master.xbyte(8'hFF, rx0);
    u_sfe_spi_master.dual_byte(rx0);
    u_sfe_spi_master.dual_byte(rx1);
    check(rx0, 8'hC6, "dual byte 0");
    check(rx1, 8'hD7, "dual byte 1");
    u_sfe_spi_master.deselect();
    check(dio_oe_n, 1'b1, "inout driven after deselect");
    check(cap_addr, 24'hABCDEF, "dual address");
  endtask

  task automatic s_pause();
    logic d0;
    logic d1;
    rd_byte_i <= 8'h5A;
    u_sfe_spi_master.select(1'b0);
    for (int i = 0; i < 4; i++) u_sfe_spi_master.sbit(1'b0, d0, d1);
    u_sfe_spi_master.set_pause(1'b0);
    check(paused, 1'b0, "paused with clock high");
    u_sfe_spi_master.half(1'b0, 6);
    check(paused, 1'b1, "not paused after fall");
    check(dout_oe_n, 1'b1, "output driven in pause");
    u_sfe_spi_master.half(1'b1, 4);
    u_sfe_spi_master.half(1'b0, 4);
    u_sfe_spi_master.set_pause(1'b1);
    check(paused, 1'b0, "pause kept with clock low");
    for (int i = 0; i < 4; i++) u_sfe_spi_master.sbit(i >= 2, d0, d1);
    u_sfe_spi_master.xbyte(8'h00, rx0);
    u_sfe_spi_master.xbyte(8'h01, rx0);
    u_sfe_spi_master.xbyte(8'h02, rx0);
    u_sfe_spi_master.xbyte(8'h00, rx0);
    check(cap_op, SFE_OP_READ, "opcode across pause");
    check(cap_addr, 24'h000102, "address across pause");
    check(rx0, 8'h5A, "data across pause");
    u_sfe_spi_master.set_pause(1'b0);
    u_sfe_spi_master.half(1'b0, 6);
    check(paused, 1'b1, "no pause after fall in read");
    check(dout_oe_n, 1'b1, "output live in pause");
    u_sfe_spi_master.set_pause(1'b1);
    u_sfe_spi_master.xbyte(8'h00, rx1);
    check(rx1, 8'h6B, "byte across output pause");
    u_sfe_spi_master.deselect();
  endtask

  task automatic s_abort();
    logic d0;
    logic d1;
    u_sfe_spi_master.select(1'b0);
    u_sfe_spi_master.sbit(1'b0, d0, d1);
    u_sfe_spi_master.half(1'b0, 4);
    u_sfe_spi_master.set_pause(1'b0);
    check(paused, 1'b1, "no pause with clock low");
    u_sfe_spi_master.half(1'b1, 4);
    u_sfe_spi_master.set_pause(1'b1);
    check(paused, 1'b0 ^ 1'b1, "left pause with clock high");
    u_sfe_spi_master.half(1'b0, 6);
    check(paused, 1'b0, "pause kept after fall");
    u_sfe_spi_master.set_pause(1'b0);
    u_sfe_spi_master.deselect();
    check(paused, 1'b0, "pause kept after deselect");
    u_sfe_spi_master.set_pause(1'b1);
    u_sfe_spi_master.set_pause(1'b0);
    check(paused, 1'b0, "pause while deselected");
    u_sfe_spi_master.set_pause(1'b1);
  endtask

  task automatic s_rdsr();
    rd_byte_i <= 8'hA5;
    dio_seen = 1'b0;
    u_sfe_spi_master.select(1'b1);
    u_sfe_spi_master.xbyte(SFE_OP_RDSR, rx0);
    u_sfe_spi_master.xbyte(8'h00, rx0);
    check(rx0, 8'hA5, "status byte");
    check(dio_seen, 1'b0, "inout driven in status read");
    u_sfe_spi_master.deselect();
    check(cap_op, SFE_OP_RDSR, "status opcode");
  endtask

  task automatic s_wrsr();
    sr_protect_i <= 1'b1;
    wp_n_i       <= 1'b0;
    u_sfe_spi_master.tick(5);
    check(req.sr_write_ok, 1'b0, "status write not blocked");
    wp_n_i <= 1'b1;
    u_sfe_spi_master.tick(5);
    check(req.sr_write_ok, 1'b1, "status write blocked, wp high");
    u_sfe_spi_master.select(1'b1);
    u_sfe_spi_master.xbyte(SFE_OP_WRSR, rx0);
    u_sfe_spi_master.xbyte(8'h9C, rx0);
    u_sfe_spi_master.deselect();
    check(cap_op, SFE_OP_WRSR, "write opcode");
    check(cap_wr, 8'h9C, "write byte");
    sr_protect_i <= 1'b0;
    wp_n_i       <= 1'b0;
    u_sfe_spi_master.tick(5);
    check(req.sr_write_ok, 1'b1, "status write blocked, no protect");
  endtask

  initial begin
    rstn_i       = 1'b0;
    wp_n_i       = 1'b1;
    sr_protect_i = 1'b0;
    rd_byte_i    = 8'h00;
    mismatches   = 0;
    check_count  = 0;
    cyc          = 0;
    op_cnt       = 0;
    dio_seen     = 1'b0;
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    u_sfe_spi_master.tick(4);
    s_arm();
    s_read(1'b0, SFE_OP_READ, 8'h81);
    s_read(1'b1, SFE_OP_READ, 8'h2E);
    s_read(1'b0, SFE_OP_FREAD, 8'h47);
    s_dual();
    s_pause();
    s_abort();
    s_read(1'b1, SFE_OP_FREAD, 8'h3C);
    s_rdsr();
    s_wrsr();
    close_out();
  end
endmodule
